// >>> hdl/foc_param_pkg.sv
// package: parameter codes, ranges, defaults and carrier structs for the foc parameter bank
package foc_param_pkg;
   // parameter codes (one byte each)
   localparam logic [7:0] CODE_PROP_GAIN    = 8'h8D;
   localparam logic [7:0] CODE_PHASE_OFFSET = 8'hE1;
   localparam logic [7:0] CODE_POLE_COUNT   = 8'h41;
   localparam logic [7:0] CODE_MIN_FREQ     = 8'hC0;
   localparam logic [7:0] CODE_BEMF_LIMIT   = 8'hBE;
   localparam logic [7:0] CODE_SWAP_WIND    = 8'hA4;
   localparam logic [7:0] CODE_ID_TARGET    = 8'h8F;
   localparam logic [7:0] CODE_CALIB        = 8'h46;
   localparam logic [7:0] CODE_DRIVE_MODE   = 8'h5F;

   // channel ranges
   localparam logic [7:0] NUM_MOTORS   = 8'h02;
   localparam logic [7:0] NUM_GAINS    = 8'h04;
   localparam logic [7:0] NUM_CALIB    = 8'h06;

   // value ranges
   localparam logic [31:0] GAIN_MAX        = 32'h7735_9400; // 2,000,000,000
   localparam logic [31:0] PHASE_MIN       = 32'hFFFF_FE01; // -511
   localparam logic [31:0] PHASE_MAX       = 32'h0000_01FF; // 511
   localparam logic [31:0] POLE_MIN        = 32'h0000_0001;
   localparam logic [31:0] POLE_MAX        = 32'h0000_00FF;
   localparam logic [31:0] FREQ_MIN        = 32'h0000_0001;
   localparam logic [31:0] FREQ_MAX        = 32'h0000_88B8; // 35000
   localparam logic [31:0] SWAP_MAX        = 32'h0000_0003;
   localparam logic [31:0] MODE_MAX        = 32'h0000_0001;

   // reset values
   localparam logic [31:0] GAIN_RST        = 32'h0000_0000;
   localparam logic [15:0] PHASE_RST       = 16'h0080;      // 128
   localparam logic [7:0]  POLE_RST        = 8'h01;
   localparam logic [15:0] FREQ_RST        = 16'h0064;      // 100
   localparam logic [31:0] BEMF_RST        = 32'h0000_03E8; // 1000
   localparam logic [1:0]  SWAP_RST        = 2'h0;
   localparam logic [31:0] ID_RST          = 32'h0000_0000;
   localparam logic [15:0] CALIB_RST       = 16'h0000;
   localparam logic        MODE_TRAP       = 1'h0;
   localparam logic        MODE_SINE       = 1'h1;

   // swap field positions
   localparam int SWAP_HALL_BIT = 1;
   localparam int SWAP_ENC_BIT  = 0;

   // host command carrier
   typedef struct packed {
      logic        valid;  // one-cycle request
      logic        write;  // 1 write, 0 query
      logic [7:0]  code;   // parameter code
      logic [7:0]  chan;   // 1-based channel index
      logic [31:0] value;  // write value
   } host_cmd_t;

   // answer carrier
   typedef struct packed {
      logic        valid;  // one-cycle answer
      logic        error;  // rejected or unknown
      logic [31:0] value;  // read-back value
   } host_rsp_t;

   // per-motor derived control outputs
   typedef struct packed {
      logic [31:0] torque_gain;   // gain routed to torque loop
      logic [31:0] flux_gain;     // 0 in trapezoidal mode
      logic        foc_active;    // sinusoidal mode uses foc
      logic        hall_reverse;  // hall angle counts down cw
      logic        enc_reverse;   // encoder angle counts down cw
      logic        field_weaken;  // nonzero direct current target
   } motor_ctl_t;
endpackage : foc_param_pkg

// >>> hdl/foc_calib_store.sv
// file: six-entry calibration memory with registered read data
`timescale 1ns/1ps
`default_nettype none
module foc_calib_store
   import foc_param_pkg::*;
(
   input  wire logic        i_clk,
   input  wire logic        i_srst,
   input  wire logic        i_we,
   input  wire logic [2:0]  i_waddr,
   input  wire logic [15:0] i_wdata,
   input  wire logic [2:0]  i_raddr,
   output logic [15:0]      o_rdata
);
   logic [15:0] mem_q [0:5];   // entries 0..5 for indices 1..6
   logic [15:0] rdata_q;       // registered read data

   // write and registered read; cleared so zero means never calibrated
   always_ff @(posedge i_clk)
   begin
      if (i_srst)
      begin
         for (int i = 0; i < 6; i++)
            mem_q[i] <= CALIB_RST;
         rdata_q <= CALIB_RST;
      end
      else
      begin
         if (i_we && i_waddr < 3'h6)
            mem_q[i_waddr] <= i_wdata;
         rdata_q <= (i_raddr < 3'h6) ? mem_q[i_raddr] : CALIB_RST;
      end
   end
   assign o_rdata = rdata_q;
endmodule : foc_calib_store
`default_nettype wire

// >>> hdl/foc_sensor_param_bank.sv
// file: per-channel foc and sensor parameter bank with command port
`timescale 1ns/1ps
`default_nettype none
module foc_sensor_param_bank
   import foc_param_pkg::*;
(
   input  wire logic        i_clk,
   input  wire logic        i_srst,
   input  wire host_cmd_t   i_cmd,          // host request
   output host_rsp_t        o_rsp,          // answer, one cycle later; two for calibration
   input  wire logic        i_setup_done,   // setup complete pulse
   input  wire logic        i_setup_motor,  // 0 motor one, 1 motor two
   input  wire logic [47:0] i_setup_calib,  // sine zero, cosine zero, ratio
   input  wire logic [15:0] i_elec_freq [2],   // measured freq, tenths hz
   input  wire logic [31:0] i_bemf_integral [2], // integral, milliwebers
   output logic [15:0]      o_commute_freq [2],  // floor-clamped frequency
   output logic [1:0]       o_commutate,         // integral reached limit
   output motor_ctl_t       o_ctl [2],
   output logic [15:0]      o_phase_offset [2],
   output logic [7:0]       o_pole_count [2]
);
   // whole state of the bank
   typedef struct packed {
      logic [3:0][31:0] gain;      // prop gains, index-1
      logic [1:0][15:0] phase;     // phase offset per motor
      logic [1:0][7:0]  poles;     // pole count per motor
      logic [1:0][15:0] freq;      // start-up frequency
      logic [1:0][31:0] bemf;      // integrator limit
      logic [1:0][1:0]  swap;      // swap windings
      logic [1:0][31:0] idt;       // direct current target
      logic [1:0]       mode;      // drive mode
      logic             pend;      // calibration read pending
      logic             rsp_vld;   // answer valid
      logic             rsp_err;   // answer error
      logic [31:0]      rsp_val;   // answer value
      logic [1:0]       comm;      // commutate flags, held while integral >= limit
      logic [1:0]       cal_cnt;   // three-word capture counter
      logic [47:0]      cal_buf;   // captured words, next one on top
      logic             cal_mot;   // motor being captured
   } state_t;

   state_t s_q;   // registered state
   state_t s_d;   // next state

   // unsigned in-range test used for the pole and frequency checks
   function automatic logic in_urange(input logic [31:0] v, input logic [31:0] lo, input logic [31:0] hi);
      in_urange = (v >= lo) && (v <= hi);
   endfunction : in_urange

   // channel check: 1..n
   function automatic logic chan_ok(input logic [7:0] c, input logic [7:0] n);
      chan_ok = (c != 8'h00) && (c <= n);
   endfunction : chan_ok

   logic [15:0] cal_rdata;          // calibration memory read
   logic [2:0]  cal_waddr;          // write row
   logic        cal_sel;            // cal write enable while a capture runs

   // a capture in progress writes one word per cycle, sine zero first
   assign cal_sel   = (s_q.cal_cnt != 2'h0);
   assign cal_waddr = 3'((s_q.cal_mot ? 3 : 0) + (3 - int'(s_q.cal_cnt)));

   foc_calib_store u_calib (
      .i_clk   (i_clk),
      .i_srst  (i_srst),
      .i_we    (cal_sel),
      .i_waddr (cal_waddr),
      .i_wdata (s_q.cal_buf[47:32]),
      .i_raddr (3'(i_cmd.chan - 8'h01)),
      .o_rdata (cal_rdata)
   );

   // command decode, range checks and answer
   always_comb
   begin
      logic        ok;
      logic [7:0]  m;
      logic [31:0] v;
      s_d = s_q;
      ok  = 1'b0;
      m   = i_cmd.chan - 8'h01;
      v   = i_cmd.value;
      s_d.rsp_vld = 1'b0;
      s_d.pend    = 1'b0;
      if (s_q.pend)
      begin
         s_d.rsp_vld = 1'b1;
         s_d.rsp_err = 1'b0;
         s_d.rsp_val = {{16{cal_rdata[15]}}, cal_rdata};
      end
      else if (i_cmd.valid)
      begin
         s_d.rsp_vld = 1'b1;
         s_d.rsp_val = 32'h0000_0000;
         unique case (i_cmd.code)
            CODE_PROP_GAIN:
            begin
               ok = chan_ok(i_cmd.chan, NUM_GAINS) && (!i_cmd.write || v <= GAIN_MAX);
               if (ok && i_cmd.write) s_d.gain[m[1:0]] = v;
               s_d.rsp_val = s_q.gain[m[1:0]];
            end
            CODE_PHASE_OFFSET:
            begin
               ok = chan_ok(i_cmd.chan, NUM_MOTORS) && (!i_cmd.write || ($signed(v) >= $signed(PHASE_MIN)
                    && $signed(v) <= $signed(PHASE_MAX)));
               if (ok && i_cmd.write) s_d.phase[m[0]] = v[15:0];
               s_d.rsp_val = {{16{s_q.phase[m[0]][15]}}, s_q.phase[m[0]]};
            end
            CODE_POLE_COUNT:
            begin
               ok = chan_ok(i_cmd.chan, NUM_MOTORS) && (!i_cmd.write || in_urange(v, POLE_MIN, POLE_MAX));
               if (ok && i_cmd.write) s_d.poles[m[0]] = v[7:0];
               s_d.rsp_val = {24'h00_0000, s_q.poles[m[0]]};
            end
            CODE_MIN_FREQ:
            begin
               ok = chan_ok(i_cmd.chan, NUM_MOTORS) && (!i_cmd.write || in_urange(v, FREQ_MIN, FREQ_MAX));
               if (ok && i_cmd.write) s_d.freq[m[0]] = v[15:0];
               s_d.rsp_val = {16'h0000, s_q.freq[m[0]]};
            end
            CODE_BEMF_LIMIT:
            begin
               ok = chan_ok(i_cmd.chan, NUM_MOTORS);
               if (ok && i_cmd.write) s_d.bemf[m[0]] = v;
               s_d.rsp_val = s_q.bemf[m[0]];
            end
            CODE_SWAP_WIND:
            begin
               ok = chan_ok(i_cmd.chan, NUM_MOTORS) && (!i_cmd.write || v <= SWAP_MAX);
               if (ok && i_cmd.write) s_d.swap[m[0]] = v[1:0];
               s_d.rsp_val = {30'h0, s_q.swap[m[0]]};
            end
            CODE_ID_TARGET:
            begin
               ok = chan_ok(i_cmd.chan, NUM_MOTORS);
               if (ok && i_cmd.write) s_d.idt[m[0]] = v;
               s_d.rsp_val = s_q.idt[m[0]];
            end
            CODE_DRIVE_MODE:
            begin
               ok = chan_ok(i_cmd.chan, NUM_MOTORS) && (!i_cmd.write || v <= MODE_MAX);
               if (ok && i_cmd.write) s_d.mode[m[0]] = v[0];
               s_d.rsp_val = {31'h0, s_q.mode[m[0]]};
            end
            CODE_CALIB:
            begin
               // calibration is read-only; the answer follows two cycles after the query
               ok = chan_ok(i_cmd.chan, NUM_CALIB) && !i_cmd.write;
               if (ok)
               begin
                  s_d.pend    = 1'b1;
                  s_d.rsp_vld = 1'b0;
               end
            end
            default: ok = 1'b0;
         endcase
         s_d.rsp_err = !ok;
         if (!ok) s_d.rsp_val = 32'h0000_0000;
      end
      // capture sequencer: a done pulse while a capture runs is ignored
      if (i_setup_done && s_q.cal_cnt == 2'h0)
      begin
         s_d.cal_cnt = 2'h3;
         s_d.cal_buf = i_setup_calib;
         s_d.cal_mot = i_setup_motor;
      end
      else if (s_q.cal_cnt != 2'h0)
      begin
         s_d.cal_cnt = s_q.cal_cnt - 2'h1;
         s_d.cal_buf = {s_q.cal_buf[31:0], 16'h0000};
      end
      // back-emf integral reaching the limit fires commutation
      for (int k = 0; k < 2; k++)
         s_d.comm[k] = (i_bemf_integral[k] >= s_q.bemf[k]);
   end

   // state register
   always_ff @(posedge i_clk)
   begin
      if (i_srst)
      begin
         s_q         <= '0;
         s_q.gain    <= {4{GAIN_RST}};
         s_q.phase   <= {2{PHASE_RST}};
         s_q.poles   <= {2{POLE_RST}};
         s_q.freq    <= {2{FREQ_RST}};
         s_q.bemf    <= {2{BEMF_RST}};
         s_q.swap    <= {2{SWAP_RST}};
         s_q.idt     <= {2{ID_RST}};
         s_q.mode    <= {2{MODE_TRAP}};
      end
      else
         s_q <= s_d;
   end

   // per-motor derived controls
   always_comb
   begin
      for (int k = 0; k < 2; k++)
      begin
         o_ctl[k].torque_gain  = s_q.gain[2 + k];
         o_ctl[k].flux_gain    = (s_q.mode[k] == MODE_SINE) ? s_q.gain[k] : GAIN_RST;
         o_ctl[k].foc_active   = (s_q.mode[k] == MODE_SINE);
         o_ctl[k].hall_reverse = s_q.swap[k][SWAP_HALL_BIT];
         o_ctl[k].enc_reverse  = s_q.swap[k][SWAP_ENC_BIT];
         o_ctl[k].field_weaken = (s_q.idt[k] != ID_RST);
         o_commute_freq[k]     = (i_elec_freq[k] < s_q.freq[k]) ? s_q.freq[k] : i_elec_freq[k];
         o_phase_offset[k]     = s_q.phase[k];
         o_pole_count[k]       = s_q.poles[k];
      end
   end

   assign o_commutate = s_q.comm;
   assign o_rsp       = '{valid: s_q.rsp_vld, error: s_q.rsp_err, value: s_q.rsp_val};

   // checks
   a_gain_bound: assert property (@(posedge i_clk) disable iff (i_srst) s_q.gain[0] <= GAIN_MAX)
      else $error("gain above limit");
   a_phase_bound: assert property (@(posedge i_clk) disable iff (i_srst)
      $signed(s_q.phase[0]) >= -16'sh01FF && $signed(s_q.phase[0]) <= 16'sh01FF)
      else $error("phase out of range");
   a_pole_nonzero: assert property (@(posedge i_clk) disable iff (i_srst) s_q.poles[1] != 8'h00)
      else $error("pole count zero");
   a_freq_floor: assert property (@(posedge i_clk) disable iff (i_srst) o_commute_freq[0] >= s_q.freq[0])
      else $error("commutation below floor");
   a_freq_bound: assert property (@(posedge i_clk) disable iff (i_srst)
      s_q.freq[0] != 16'h0000 && s_q.freq[0] <= 16'h88B8)
      else $error("frequency out of range");
   // a command in the cycle after a calibration query is ignored, so the checks skip it
   a_reject_keep: assert property (@(posedge i_clk) disable iff (i_srst)
      i_cmd.valid && !s_q.pend && i_cmd.write && i_cmd.code == CODE_SWAP_WIND && i_cmd.value > SWAP_MAX
      |=> $stable(s_q.swap) && o_rsp.valid && o_rsp.error)
      else $error("bad swap write accepted");
   a_trap_flux: assert property (@(posedge i_clk) disable iff (i_srst)
      s_q.mode[0] == MODE_TRAP |-> o_ctl[0].flux_gain == GAIN_RST && !o_ctl[0].foc_active)
      else $error("flux gain used in trapezoidal");
   a_comm_fire: assert property (@(posedge i_clk) disable iff (i_srst)
      i_bemf_integral[1] >= s_q.bemf[1] && $stable(s_q.bemf[1]) |=> o_commutate[1])
      else $error("missed commutation");
   a_cal_answer: assert property (@(posedge i_clk) disable iff (i_srst)
      i_cmd.valid && !s_q.pend && !i_cmd.write && i_cmd.code == CODE_CALIB && chan_ok(i_cmd.chan, NUM_CALIB)
      |=> !o_rsp.valid ##1 o_rsp.valid && !o_rsp.error)
      else $error("calibration answer late");
   a_field_weaken: assert property (@(posedge i_clk) disable iff (i_srst)
      i_cmd.valid && !s_q.pend && i_cmd.write && i_cmd.code == CODE_ID_TARGET && i_cmd.chan == 8'h01
      && i_cmd.value != 32'h0000_0000 |=> o_ctl[0].field_weaken)
      else $error("field weaken wrong");

   c_gain_write: cover property (@(posedge i_clk) i_cmd.valid && i_cmd.write && i_cmd.code == CODE_PROP_GAIN);
   c_reject: cover property (@(posedge i_clk) o_rsp.valid && o_rsp.error);
   c_cal_read: cover property (@(posedge i_clk) s_q.pend ##1 o_rsp.valid && o_rsp.value != 32'h0000_0000);
   c_floor: cover property (@(posedge i_clk) i_elec_freq[0] < s_q.freq[0]);
endmodule : foc_sensor_param_bank
`default_nettype wire

// >>> verification/foc_host_model.sv
// host model: issues one command at a time and collects its answer
`timescale 1ns/1ps
`default_nettype none
module foc_host_model
   import foc_param_pkg::*;
(
   input  wire logic      i_clk,
   input  wire host_rsp_t i_rsp,
   output host_cmd_t      o_cmd
);
   // idle bus at time zero so the bank never sees an unknown request
   initial o_cmd = '0;

   // one request pulse, then wait a bounded time for the answer
   task automatic issue(input logic w, input logic [7:0] cd, input logic [7:0] ch,
                        input logic [31:0] v, output host_rsp_t r);
      int n;
      r = '0;
      @(posedge i_clk);
      o_cmd <= '{valid: 1'h1, write: w, code: cd, chan: ch, value: v};
      @(posedge i_clk);
      o_cmd <= '0; // valid is a one-cycle pulse; no stale value left behind
      // sampling at the falling edge keeps clear of the register update
      for (n = 0; n < 4; n++)
      begin
         @(negedge i_clk);
         if (i_rsp.valid === 1'h1)
         begin
            r = i_rsp;
            break;
         end
      end
      // waiting for the answer also gives the idle cycle after a calibration query
   endtask : issue
endmodule : foc_host_model
`default_nettype wire

// >>> verification/foc_sensor_param_bank_bench.sv
// testbench for the foc sensor parameter bank
`timescale 1ns/1ps
`default_nettype none
module foc_sensor_param_bank_bench;
   import foc_param_pkg::*;
   typedef struct packed {
      logic w; logic [7:0] cd; logic [7:0] ch; logic [31:0] v; logic e; logic [31:0] x;
   } row_t; // request beside expected error and value
   localparam int ND = 10; // rows that only query reset values
   localparam int NR = 36;
   logic        i_clk;
   logic        i_srst;
   host_cmd_t   cmd;          // from the host model
   host_rsp_t   rsp;          // answer port
   host_rsp_t   r;            // last captured answer
   logic        setup_done;
   logic        setup_motor;
   logic [47:0] setup_calib;
   logic [15:0] elec_freq [2];
   logic [31:0] bemf [2];
   logic [15:0] comm_freq [2];
   logic [1:0]  commutate;
   motor_ctl_t  ctl [2];
   logic [15:0] phase [2];
   logic [7:0]  poles [2];
   int          bad_count;
   int          comparisons;
   // query rows first, then writes that depend on earlier rows
   row_t rows [NR] = '{
      '{1'h0,8'h8D,8'h01,32'h0,1'h0,32'h0}, '{1'h0,8'h8D,8'h04,32'h0,1'h0,32'h0},
      '{1'h0,8'hE1,8'h02,32'h0,1'h0,32'h80}, '{1'h0,8'h41,8'h02,32'h0,1'h0,32'h1},
      '{1'h0,8'hC0,8'h01,32'h0,1'h0,32'h64}, '{1'h0,8'hBE,8'h02,32'h0,1'h0,32'h3E8},
      '{1'h0,8'hA4,8'h01,32'h0,1'h0,32'h0}, '{1'h0,8'h8F,8'h02,32'h0,1'h0,32'h0},
      '{1'h0,8'h46,8'h06,32'h0,1'h0,32'h0}, '{1'h0,8'h5F,8'h01,32'h0,1'h0,32'h0},
      '{1'h1,8'h8D,8'h04,32'h38270,1'h0,32'h0}, '{1'h0,8'h8D,8'h04,32'h0,1'h0,32'h38270},
      '{1'h1,8'h8D,8'h05,32'h1,1'h1,32'h0}, '{1'h1,8'h8D,8'h00,32'h1,1'h1,32'h0},
      '{1'h1,8'h8D,8'h03,32'h77359400,1'h0,32'h0}, '{1'h1,8'h8D,8'h03,32'h77359401,1'h1,32'h0},
      '{1'h1,8'h8D,8'h01,32'h7,1'h0,32'h0}, '{1'h1,8'hE1,8'h01,32'hFFFFFE01,1'h0,32'h80},
      '{1'h1,8'hE1,8'h01,32'hFFFFFE00,1'h1,32'h0}, '{1'h1,8'hE1,8'h03,32'h0,1'h1,32'h0},
      '{1'h1,8'h41,8'h01,32'h0,1'h1,32'h0}, '{1'h1,8'h41,8'h01,32'hFF,1'h0,32'h1},
      '{1'h1,8'h41,8'h01,32'h100,1'h1,32'h0}, '{1'h1,8'hC0,8'h02,32'h0,1'h1,32'h0},
      '{1'h1,8'hC0,8'h02,32'h88B8,1'h0,32'h64}, '{1'h1,8'hC0,8'h02,32'h88B9,1'h1,32'h0},
      '{1'h1,8'hBE,8'h01,32'h5DC,1'h0,32'h3E8}, '{1'h1,8'hA4,8'h01,32'h4,1'h1,32'h0},
      '{1'h1,8'hA4,8'h01,32'h3,1'h0,32'h0}, '{1'h1,8'hA4,8'h02,32'h2,1'h0,32'h0},
      '{1'h1,8'h8F,8'h01,32'hFFFFFFFB,1'h0,32'h0}, '{1'h1,8'h5F,8'h01,32'h1,1'h0,32'h0},
      '{1'h1,8'h5F,8'h02,32'h2,1'h1,32'h0}, '{1'h1,8'h46,8'h01,32'h5,1'h1,32'h0},
      '{1'h1,8'h00,8'h01,32'h0,1'h1,32'h0}, '{1'h0,8'h8D,8'h03,32'h0,1'h0,32'h77359400}
   };

   foc_host_model host (.i_clk(i_clk), .i_rsp(rsp), .o_cmd(cmd));

   foc_sensor_param_bank dut (
      .i_clk(i_clk), .i_srst(i_srst), .i_cmd(cmd), .o_rsp(rsp),
      .i_setup_done(setup_done), .i_setup_motor(setup_motor), .i_setup_calib(setup_calib),
      .i_elec_freq(elec_freq), .i_bemf_integral(bemf), .o_commute_freq(comm_freq),
      .o_commutate(commutate), .o_ctl(ctl), .o_phase_offset(phase), .o_pole_count(poles));

   // 100 MHz clock
   initial
   begin
      i_clk = 1'h0;
      forever #5 i_clk = ~i_clk;
   end

   // one comparison, counted, mismatch printed at once
   task automatic chk(input logic [31:0] g, input logic [31:0] e);
      comparisons++;
      if (g !== e)
      begin
         bad_count++;
         $display("mismatch at %0t: got %h expected %h", $time, g, e);
      end
   endtask : chk

   // verdict and end of run
   task automatic wrap_up();
      if (bad_count == 0 && comparisons > 0)
         $display("Testbench passed");
      else
         $display("Testbench failed");
      $finish;
   endtask : wrap_up

   // replay a span of table rows through the host model
   task automatic run_rows(input int lo, input int hi);
      for (int k = lo; k < hi; k++)
      begin
         host.issue(rows[k].w, rows[k].cd, rows[k].ch, rows[k].v, r);
         chk(32'(r.valid), 32'h1);
         chk(32'(r.error), 32'(rows[k].e));
         chk(r.value, rows[k].x);
      end
   endtask : run_rows

   // watchdog: the whole run needs fewer than two hundred cycles
   initial
   begin
      #200us;
      bad_count++;
      wrap_up();
   end

   // main sequence
   initial
   begin
      bad_count = 0;
      comparisons = 0;
      i_srst = 1'h1;
      setup_done = 1'h0;
      setup_motor = 1'h0;
      setup_calib = 48'h0;
      elec_freq = '{16'h0, 16'h0};
      bemf = '{32'h0, 32'h0};
      repeat (16) @(posedge i_clk);
      i_srst <= 1'h0;
      run_rows(0, NR);
      // derived outputs after the writes above
      chk(ctl[0].torque_gain, 32'h77359400);
      chk(ctl[1].torque_gain, 32'h38270);
      chk(ctl[0].flux_gain, 32'h7);
      chk(ctl[1].flux_gain, 32'h0);
      chk(32'({ctl[0].foc_active, ctl[1].foc_active}), 32'h2);
      chk(32'({ctl[0].hall_reverse, ctl[0].enc_reverse, ctl[1].hall_reverse, ctl[1].enc_reverse}), 32'hE);
      chk(32'({ctl[0].field_weaken, ctl[1].field_weaken}), 32'h2);
      chk(32'(phase[0]), 32'hFE01);
      chk(32'(poles[0]), 32'hFF);
      // frequency floor and integrator threshold
      @(posedge i_clk);
      elec_freq <= '{16'h1F4, 16'hA};
      bemf <= '{32'h5DC, 32'h3E7};
      repeat (2) @(posedge i_clk);
      @(negedge i_clk);
      chk(32'(comm_freq[0]), 32'h1F4);
      chk(32'(comm_freq[1]), 32'h88B8);
      chk(32'(commutate), 32'h1);
      @(posedge i_clk);
      bemf <= '{32'h5DB, 32'h3E8};
      repeat (2) @(posedge i_clk);
      @(negedge i_clk);
      chk(32'(commutate), 32'h2);
      // calibration capture for motor two
      @(posedge i_clk);
      setup_done <= 1'h1;
      setup_motor <= 1'h1;
      setup_calib <= 48'h0012_FFF0_0400;
      @(posedge i_clk);
      setup_done <= 1'h0;
      repeat (5) @(posedge i_clk);
      host.issue(1'h0, 8'h46, 8'h04, 32'h0, r);
      chk(r.value, 32'h12);
      host.issue(1'h0, 8'h46, 8'h05, 32'h0, r);
      chk(r.value, 32'hFFFFFFF0);
      host.issue(1'h0, 8'h46, 8'h06, 32'h0, r);
      chk(r.value, 32'h400);
      host.issue(1'h0, 8'h46, 8'h01, 32'h0, r);
      chk(r.value, 32'h0);
      // motor one capture; a second done inside the capture must be ignored
      @(posedge i_clk);
      setup_done <= 1'h1;
      setup_motor <= 1'h0;
      setup_calib <= 48'h8001_0002_7FFF;
      @(posedge i_clk);
      setup_calib <= 48'h1111_1111_1111;
      @(posedge i_clk);
      setup_done <= 1'h0;
      repeat (4) @(posedge i_clk);
      host.issue(1'h0, 8'h46, 8'h01, 32'h0, r);
      chk(r.value, 32'hFFFF8001);
      host.issue(1'h0, 8'h46, 8'h03, 32'h0, r);
      chk(r.value, 32'h7FFF);
      host.issue(1'h0, 8'h46, 8'h04, 32'h0, r);
      chk(r.value, 32'h12);
      // second reset in mid-run restores every default
      @(posedge i_clk);
      i_srst <= 1'h1;
      repeat (2) @(posedge i_clk);
      @(negedge i_clk);
      chk(32'({rsp.valid, rsp.error}), 32'h0);
      chk(rsp.value, 32'h0);
      chk(32'(commutate), 32'h0);
      @(posedge i_clk);
      i_srst <= 1'h0;
      run_rows(0, ND);
      wrap_up();
   end
endmodule : foc_sensor_param_bank_bench
`default_nettype wire
